// ==== msmm_clkgen.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "msmm_defs.svh"
module msmm_clkgen (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Derived phases
  output logic      tick_o,
  output logic [5:0] clks_o
);
  // ==========================================
  // Crystal-rate divider and phase counter
  logic [`MSMM_DIVCNT_W-1:0] div;
  logic [3:0]                ph;
  logic [1:0]                c3cnt;
  logic                      c16;
  logic                      c3;
  wire                       wrap = (div == `MSMM_DIVCNT_W'(`MSMM_C16_DIV - 1));
  wire                       half = (div == `MSMM_DIVCNT_W'(`MSMM_C16_DIV / 2));
  wire                       stretch = (ph == `MSMM_STRETCH_PH);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div    <= '0;
      ph     <= 4'h0;
      c3cnt  <= 2'h0;
      c16    <= 1'b0;
      c3     <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      div    <= wrap ? '0 : div + 1'b1;          // [R1]
      tick_o <= wrap;
      if (wrap) c16 <= 1'b1;
      else if (half) c16 <= 1'b0;
      if (wrap) begin
        ph <= ph + 4'h1;
        if (!stretch) c3cnt <= c3cnt + 2'h1;     // [R1]
        if (!stretch && c3cnt == `MSMM_C3_LAST) c3 <= ~c3;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) clks_o <= 6'h00;
    else clks_o <= {c16, ph[0], ph[1], c3, ph[2], ph[3]};
  end
endmodule : msmm_clkgen
`default_nettype wire

// ==== msmm_defs.svh ====
`ifndef MSMM_DEFS_SVH
`define MSMM_DEFS_SVH
// ==========================================
// Clock derivation
`define MSMM_CLK_KHZ      200000
`define MSMM_XTAL_KHZ     31334
`define MSMM_C16_DIV      ((`MSMM_CLK_KHZ * 2) / `MSMM_XTAL_KHZ)
`define MSMM_DIVCNT_W     4
`define MSMM_STRETCH_PH   4'hF
`define MSMM_C3_LAST      2'h3
// ==========================================
// Address space
`define MSMM_REG_HI       23
`define MSMM_REG_LO       22
`define MSMM_REG_RAM      2'h0
`define MSMM_REG_ROM      2'h1
`define MSMM_REG_MAP      2'h2
`define MSMM_REG_IO       2'h3
`define MSMM_PAGE_HI      20
`define MSMM_PAGE_LO      11
`define MSMM_OFFS_HI      10
`define MSMM_IO_HI        21
`define MSMM_IO_LO        20
`define MSMM_SUPER_CTX    3'h0
// ==========================================
// Page entry layout
`define MSMM_ENT_FAULT    15
`define MSMM_ENT_WPROT    14
`define MSMM_ENT_PPN_HI   11
`define MSMM_ENT_PPN_RAM  8
`define MSMM_MAP_DEPTH    8192
`endif

// ==== msmm_dma_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Disk DMA requester and RAM array
module msmm_dma_model (
  // Clock, reset and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  input  wire logic [3:0]  count_i,
  // Block side
  input  wire logic        dma_ack_i,
  input  wire logic [19:1] ram_addr_i,
  input  wire logic        ram_cas_n_i,
  input  wire logic        ram_from_cpu_i,
  output logic             dma_req_o,
  output logic [19:1]      dma_addr_o,
  output logic             dma_we_o,
  output logic [15:0]      ram_data_o
);
  logic [3:0]  left;
  logic [15:0] pat;
  assign pat = ram_addr_i[16:1] ^ 16'h5A5A;
  // Released bus shows the inverse pattern
  assign ram_data_o = (ram_from_cpu_i || !ram_cas_n_i) ? pat : ~pat;
  assign dma_req_o = (left != 4'h0);
  assign dma_we_o = dma_addr_o[1];
  // Request held until acknowledged, then next word of the top buffer
  always @(posedge clk_i) begin
    if (rst_i) begin
      left <= 4'h0;
      dma_addr_o <= 19'h7FE00;
    end else if (load_i) begin
      left <= count_i;
    end else if (dma_ack_i && left != 4'h0) begin
      left <= left - 4'h1;
      dma_addr_o <= dma_addr_o + 19'h1;
    end
  end
endmodule : msmm_dma_model
`default_nettype wire

// ==== msmm_pkg.sv ====
package msmm_pkg;
  typedef logic [12:0] msmm_idx_t;
  typedef logic [15:0] msmm_word_t;
  typedef logic [2:0]  msmm_ctx_t;
endpackage : msmm_pkg

// ==== msmm_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bus and strobe checker
module msmm_properties (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // Observed ports
  input wire logic [23:1] CPU_ADDR_I,
  input wire logic        CPU_SUPER_I,
  input wire logic        OVERLAY_I,
  input wire logic        CPU_DTACK_N_O,
  input wire logic        CPU_BERR_N_O,
  input wire logic        DMA_ACK_O,
  input wire logic [19:1] RAM_ADDR_O,
  input wire logic        RAM_RAS_N_O,
  input wire logic        RAM_CAS_N_O,
  input wire logic        RAM_FROM_CPU_O,
  input wire logic [3:0]  PERIPH_SEL_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_resp_excl: assert property (CPU_DTACK_N_O || CPU_BERR_N_O) else $error("dtack with berr");
  a_dtack_stands: assert property ($fell(CPU_DTACK_N_O) |-> (!CPU_DTACK_N_O) [*8]) else $error("dtack short");
  a_cas_after_ras: assert property ($fell(RAM_CAS_N_O) |-> !RAM_RAS_N_O) else $error("cas without ras");
  a_dma_ack_pulse: assert property (DMA_ACK_O |=> !DMA_ACK_O) else $error("dma ack long");
  a_dma_not_cpu: assert property (DMA_ACK_O |-> !RAM_FROM_CPU_O) else $error("cpu buffer in dma");
  a_dma_no_dtack: assert property (!RAM_RAS_N_O && !RAM_FROM_CPU_O |-> CPU_DTACK_N_O) else $error("dtack in dma");
  a_offset_pass: assert property (!RAM_CAS_N_O && RAM_FROM_CPU_O |-> RAM_ADDR_O[10:1] == CPU_ADDR_I[10:1])
    else $error("offset changed");
  a_user_io_ack: assert property ($fell(CPU_DTACK_N_O) |-> !(CPU_ADDR_I[23:22] == 2'h3 && !CPU_SUPER_I))
    else $error("user io acked");
  a_super_ram_ok: assert property ($fell(CPU_BERR_N_O) |-> !(CPU_SUPER_I && CPU_ADDR_I[23:22] == 2'h0 && !OVERLAY_I))
    else $error("supervisor ram fault");
  a_sel_super: assert property (PERIPH_SEL_N_O != 4'hF |-> CPU_SUPER_I && $onehot(~PERIPH_SEL_N_O))
    else $error("bad select");
endmodule : msmm_properties
bind msmm_top msmm_properties u_props (.CLK_I(CLK_I), .RST_I(RST_I), .CPU_ADDR_I(CPU_ADDR_I),
  .CPU_SUPER_I(CPU_SUPER_I), .OVERLAY_I(OVERLAY_I), .CPU_DTACK_N_O(CPU_DTACK_N_O),
  .CPU_BERR_N_O(CPU_BERR_N_O), .DMA_ACK_O(DMA_ACK_O), .RAM_ADDR_O(RAM_ADDR_O), .RAM_RAS_N_O(RAM_RAS_N_O),
  .RAM_CAS_N_O(RAM_CAS_N_O), .RAM_FROM_CPU_O(RAM_FROM_CPU_O), .PERIPH_SEL_N_O(PERIPH_SEL_N_O));
`default_nettype wire

// ==== msmm_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "msmm_defs.svh"
// Overview of operation
// [R1] Derive every clock from one crystal rate
// [R2] Combine phases with bus signals into strobes
// [R3] Disk DMA wins RAM over processor
// [R4] Withhold acknowledge while DMA owns RAM
// [R5] Map high address bits through page table
// [R6] Fixed pages, one table of 1024 entries per context
// [R7] Physical RAM smaller than virtual space
// [R8] Fault bit blocks all, protect blocks writes
// [R9] Page protection only in user state
// [R10] User access to I/O space refused
// [R11] Violation raises bus error to processor
// [R12] Supervisor uses context zero, user register
// [R13] Entry: fault 15, protect 14, page 11..0
// [R14] In-page offset bits pass untranslated
// [R15] Stalled access rechecked after release
module msmm_top
  import msmm_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RST_I,
  // Processor bus
  input  wire logic [23:1]         CPU_ADDR_I,
  input  wire logic                CPU_AS_N_I,
  input  wire logic                CPU_RW_I,
  input  wire logic [1:0]          CPU_DS_N_I,
  input  wire logic                CPU_SUPER_I,
  input  wire msmm_pkg::msmm_word_t CPU_DATA_I,
  output logic                     CPU_DTACK_N_O,
  output logic                     CPU_BERR_N_O,
  output msmm_pkg::msmm_word_t     CPU_DATA_O,
  output logic                     CPU_DATA_OE_O,
  // Control inputs
  input  wire msmm_pkg::msmm_ctx_t CONTEXT_I,
  input  wire logic                OVERLAY_I,
  // Disk DMA requester
  input  wire logic                DMA_REQ_I,
  input  wire logic [19:1]         DMA_ADDR_I,
  input  wire logic                DMA_WE_I,
  output logic                     DMA_ACK_O,
  // RAM side
  output logic [19:1]              RAM_ADDR_O,
  output logic                     RAM_RAS_N_O,
  output logic                     RAM_CAS_N_O,
  output logic                     RAM_WE_N_O,
  output logic [1:0]               RAM_BE_N_O,
  output logic                     RAM_FROM_CPU_O,
  input  wire msmm_pkg::msmm_word_t RAM_DATA_I,
  // ROM and peripherals
  output logic                     ROM_OE_N_O,
  output logic [3:0]               PERIPH_SEL_N_O,
  // Derived clocks: C16 C8 C4 C3 C2 C1
  output logic [5:0]               CLKS_O
);
  import msmm_pkg::*;
  typedef enum logic [10:0] {
    ST_IDLE    = 11'b00000000001,
    ST_CHECK   = 11'b00000000010,
    ST_DMA_RAS = 11'b00000000100,
    ST_DMA_CAS = 11'b00000001000,
    ST_CPU_RAS = 11'b00000010000,
    ST_CPU_CAS = 11'b00000100000,
    ST_MAP     = 11'b00001000000,
    ST_ROM     = 11'b00010000000,
    ST_IO      = 11'b00100000000,
    ST_ACK     = 11'b01000000000,
    ST_BERR    = 11'b10000000000
  } msmm_state_t;
  // ==========================================
  // Helper functions
  function automatic msmm_idx_t map_index(input msmm_ctx_t ctx, input logic [9:0] page);
    map_index = {ctx, page};                                          // [R6]
  endfunction : map_index
  function automatic logic violates(input msmm_word_t ent, input logic user, input logic wr);
    violates = user & (ent[`MSMM_ENT_FAULT] | (ent[`MSMM_ENT_WPROT] & wr)); // [R8] [R9] [R13]
  endfunction : violates
  // ==========================================
  // Clock generator
  logic tick;
  msmm_clkgen u_clkgen (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .tick_o (tick),
    .clks_o (CLKS_O)
  );                                                                  // [R1]
  // ==========================================
  // Address decode
  msmm_state_t state;
  msmm_state_t next_state;
  msmm_word_t  map_mem [0:`MSMM_MAP_DEPTH-1];
  msmm_word_t  entry;
  logic        done;
  wire  [1:0]  region   = CPU_ADDR_I[`MSMM_REG_HI:`MSMM_REG_LO];
  wire         user     = ~CPU_SUPER_I;
  wire         cpu_wr   = ~CPU_RW_I;
  wire         as       = ~CPU_AS_N_I & ~done;
  wire         is_ram   = (region == `MSMM_REG_RAM) & ~OVERLAY_I;
  wire         is_rom   = (region == `MSMM_REG_ROM) | ((region == `MSMM_REG_RAM) & OVERLAY_I);
  wire         is_map   = (region == `MSMM_REG_MAP);
  wire         is_io    = (region == `MSMM_REG_IO);
  wire [9:0]   page     = CPU_ADDR_I[`MSMM_PAGE_HI:`MSMM_PAGE_LO];
  wire msmm_ctx_t ram_ctx = CPU_SUPER_I ? `MSMM_SUPER_CTX : CONTEXT_I; // [R12]
  wire msmm_idx_t ram_idx = map_index(ram_ctx, page);
  wire msmm_idx_t tbl_idx = map_index(CONTEXT_I, page);
  wire msmm_idx_t rd_idx  = is_map ? tbl_idx : ram_idx;
  wire         ram_bad  = violates(entry, user, cpu_wr);
  wire [19:1]  cpu_phys = {entry[`MSMM_ENT_PPN_RAM:0], CPU_ADDR_I[`MSMM_OFFS_HI:1]}; // [R5] [R7] [R14]
  wire [1:0]   io_sel   = CPU_ADDR_I[`MSMM_IO_HI:`MSMM_IO_LO];
  wire         map_wr   = (state == ST_MAP) & tick & cpu_wr;
  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (DMA_REQ_I) next_state = ST_DMA_RAS;                       // [R3]
        else if (as) next_state = ST_CHECK;
      end
      ST_CHECK: begin
        if (!as) next_state = ST_IDLE;
        else if (is_ram && ram_bad) next_state = ST_BERR;             // [R11]
        else if (is_ram && DMA_REQ_I) next_state = ST_IDLE;           // [R4] [R15]
        else if (is_ram) next_state = ST_CPU_RAS;
        else if ((is_io || is_map) && user) next_state = ST_BERR;     // [R10] [R11]
        else if (is_map) next_state = ST_MAP;
        else if (is_io) next_state = ST_IO;
        else if (is_rom) next_state = ST_ROM;
      end
      ST_DMA_RAS: next_state = ST_DMA_CAS;
      ST_DMA_CAS: next_state = ST_IDLE;
      ST_CPU_RAS: next_state = ST_CPU_CAS;
      ST_CPU_CAS: next_state = ST_ACK;
      ST_MAP:     next_state = ST_ACK;
      ST_ROM:     next_state = ST_ACK;
      ST_IO:      next_state = ST_ACK;
      ST_ACK:     next_state = ST_IDLE;
      ST_BERR:    next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) state <= ST_IDLE;
    else if (tick) state <= next_state;                               // [R2]
  end
  // One bus cycle per address strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I || CPU_AS_N_I) done <= 1'b0;
    else if (tick && (state == ST_ACK || state == ST_BERR)) done <= 1'b1;
  end
  // ==========================================
  // Page table
  always_ff @(posedge CLK_I) begin
    entry <= map_mem[rd_idx];                                         // [R5]
    if (map_wr) map_mem[tbl_idx] <= CPU_DATA_I;
  end
  // ==========================================
  // Strobes
  wire dma_st = (state == ST_DMA_RAS) | (state == ST_DMA_CAS);
  wire cpu_st = (state == ST_CPU_RAS) | (state == ST_CPU_CAS);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RAM_ADDR_O     <= '0;
      RAM_RAS_N_O    <= 1'b1;
      RAM_CAS_N_O    <= 1'b1;
      RAM_WE_N_O     <= 1'b1;
      RAM_BE_N_O     <= 2'h3;
      RAM_FROM_CPU_O <= 1'b0;
      DMA_ACK_O      <= 1'b0;
      ROM_OE_N_O     <= 1'b1;
      PERIPH_SEL_N_O <= 4'hF;
    end else begin
      RAM_ADDR_O     <= dma_st ? DMA_ADDR_I : cpu_phys;               // [R3] [R14]
      RAM_RAS_N_O    <= ~(dma_st | cpu_st);                           // [R2]
      RAM_CAS_N_O    <= ~((state == ST_DMA_CAS) | (state == ST_CPU_CAS));
      RAM_WE_N_O     <= ~(dma_st ? DMA_WE_I : (cpu_st & cpu_wr));
      RAM_BE_N_O     <= dma_st ? 2'h0 : (cpu_st ? CPU_DS_N_I : 2'h3);
      RAM_FROM_CPU_O <= cpu_st;
      DMA_ACK_O      <= (state == ST_DMA_CAS) & tick;                 // [R3]
      ROM_OE_N_O     <= ~(state == ST_ROM);                           // [R2]
      PERIPH_SEL_N_O <= ~(4'h1 << io_sel) | {4{state != ST_IO}};
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CPU_DTACK_N_O <= 1'b1;
      CPU_BERR_N_O  <= 1'b1;
      CPU_DATA_O    <= '0;
      CPU_DATA_OE_O <= 1'b0;
    end else begin
      CPU_DTACK_N_O <= ~(state == ST_ACK);                            // [R4]
      CPU_BERR_N_O  <= ~(state == ST_BERR);                           // [R11]
      if (state == ST_CPU_CAS) CPU_DATA_O <= RAM_DATA_I;
      else if (state == ST_MAP) CPU_DATA_O <= entry;
      CPU_DATA_OE_O <= CPU_RW_I & (state == ST_ACK) & ~CPU_AS_N_I;
    end
  end
endmodule : msmm_top
`default_nettype wire

// ==== test_memory_state_machine_mapper.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Testbench
module test_memory_state_machine_mapper;
  import msmm_pkg::*;
  logic CLK_I = 0, RST_I = 1, cpu_as_n = 1, cpu_rw = 1, cpu_super = 1, overlay = 0, load = 0;
  logic [23:1] cpu_addr = '0;
  logic [1:0] cpu_ds_n = 2'h3, be_n;
  logic [3:0] cnt = 4'h6, sel_n, sel_acc;
  logic [19:1] dma_addr, ram_addr;
  logic [5:0] clks;
  msmm_word_t cpu_wdata = '0, cpu_rdata, ram_data;
  msmm_ctx_t ctx = '0;
  logic dtack_n, berr_n, oe, dma_req, dma_we, dma_ack, ras_n, cas_n, we_n, from_cpu, rom_oe_n, e, rom_acc, oe_seen;
  logic [2:0] wb;
  logic [19:1] ra;
  msmm_word_t rd;
  int failures = 0, num_checks = 0, acks = 0;
  msmm_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .CPU_ADDR_I(cpu_addr), .CPU_AS_N_I(cpu_as_n), .CPU_RW_I(cpu_rw),
    .CPU_DS_N_I(cpu_ds_n), .CPU_SUPER_I(cpu_super), .CPU_DATA_I(cpu_wdata), .CPU_DTACK_N_O(dtack_n),
    .CPU_BERR_N_O(berr_n), .CPU_DATA_O(cpu_rdata), .CPU_DATA_OE_O(oe), .CONTEXT_I(ctx), .OVERLAY_I(overlay),
    .DMA_REQ_I(dma_req), .DMA_ADDR_I(dma_addr), .DMA_WE_I(dma_we), .DMA_ACK_O(dma_ack), .RAM_ADDR_O(ram_addr),
    .RAM_RAS_N_O(ras_n), .RAM_CAS_N_O(cas_n), .RAM_WE_N_O(we_n), .RAM_BE_N_O(be_n), .RAM_FROM_CPU_O(from_cpu),
    .RAM_DATA_I(ram_data), .ROM_OE_N_O(rom_oe_n), .PERIPH_SEL_N_O(sel_n), .CLKS_O(clks));
  msmm_dma_model u_dma (.clk_i(CLK_I), .rst_i(RST_I), .load_i(load), .count_i(cnt), .dma_ack_i(dma_ack),
    .ram_addr_i(ram_addr), .ram_cas_n_i(cas_n), .ram_from_cpu_i(from_cpu), .dma_req_o(dma_req),
    .dma_addr_o(dma_addr), .dma_we_o(dma_we), .ram_data_o(ram_data));
  always #2.5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) if (dma_ack === 1'b1) acks <= acks + 1;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cpu(input logic [23:1] a, input logic w, input logic s, input msmm_word_t d);
    int n;
    @(posedge CLK_I); #1;
    {cpu_addr, cpu_rw, cpu_super, cpu_wdata, cpu_ds_n, cpu_as_n} = {a, ~w, s, d, 3'h0};
    {ra, wb, sel_acc, rom_acc, n} = {19'hx, 3'hx, 4'hF, 1'b1, 32'h0};
    while (dtack_n !== 1'b0 && berr_n !== 1'b0 && n < 600) begin
      @(posedge CLK_I); #1;
      if (!cas_n && from_cpu) {ra, wb} = {ram_addr, we_n, be_n};
      sel_acc = sel_acc & sel_n;
      rom_acc = rom_acc & rom_oe_n;
      n++;
    end
    if (n >= 600) begin
      failures++;
      $display("ERROR %0t: no bus answer", $time);
    end
    @(posedge CLK_I); #1;
    {e, rd, oe_seen, cpu_as_n, n} = {!berr_n, cpu_rdata, oe, 1'b1, 32'h0};
    while ((dtack_n !== 1'b1 || berr_n !== 1'b1) && n < 40) begin
      @(posedge CLK_I); #1;
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("ERROR %0t: answer never released", $time);
    end
  endtask : cpu
  task automatic mapw(input msmm_ctx_t c, input logic [9:0] pg, input msmm_word_t d);
    ctx = c;
    cpu({3'h4, pg, 10'h0}, 1, 1, d);
  endtask : mapw
  task automatic t_map;
    mapw(0, 10'h5, 16'h01A3);
    mapw(3, 10'h5, 16'h0077);
    cpu({3'h4, 10'h5, 10'h0}, 0, 1, 0);
    check(rd, 16'h0077);
    cpu({3'h0, 10'h5, 10'h123}, 0, 1, 0);
    check(ra, {9'h1A3, 10'h123});
    check(rd, {6'h23, 10'h123} ^ 16'h5A5A);
    check({oe_seen, wb}, {1'b1, 3'b100});
    cpu({3'h0, 10'h5, 10'h0F0}, 0, 0, 0);
    check(ra, {9'h077, 10'h0F0});
    $display("t_map done");
  endtask : t_map
  task automatic t_prot;
    mapw(3, 10'h7, 16'h4011);
    mapw(3, 10'h8, 16'h8022);
    mapw(0, 10'h8, 16'hC033);
    ctx = 3;
    cpu({3'h0, 10'h7, 10'h1}, 0, 0, 0);
    check({e, ra}, {1'b0, 9'h011, 10'h1});
    cpu({3'h0, 10'h7, 10'h2}, 1, 0, 0);
    check(e, 1);
    cpu({3'h0, 10'h8, 10'h3}, 0, 0, 0);
    check(e, 1);
    cpu({3'h0, 10'h8, 10'h4}, 1, 1, 0);
    check({e, ra}, {1'b0, 9'h033, 10'h4});
    check({oe_seen, wb}, 4'h0);
    $display("t_prot done");
  endtask : t_prot
  task automatic t_io;
    cpu({2'h3, 2'h2, 19'h0}, 0, 0, 0);
    check({e, sel_acc}, 5'h1F);
    cpu({3'h4, 10'h5, 10'h0}, 0, 0, 0);
    check(e, 1);
    cpu({2'h3, 2'h2, 19'h0}, 0, 1, 0);
    check({e, sel_acc}, 5'h0B);
    overlay = 1;
    cpu({3'h0, 10'h5, 10'h0}, 0, 1, 0);
    overlay = 0;
    check({e, rom_acc, oe_seen}, 3'b001);
    $display("t_io done");
  endtask : t_io
  task automatic t_dma;
    int a0;
    a0 = acks;
    @(posedge CLK_I); #1;
    load = 1;
    @(posedge CLK_I); #1;
    load = 0;
    cpu({3'h0, 10'h5, 10'h3FF}, 0, 1, 0);
    check(acks - a0, 6);
    check(ra, {9'h1A3, 10'h3FF});
    check(rd, {6'h23, 10'h3FF} ^ 16'h5A5A);
    // Request lands while the processor cycle is being checked
    a0 = acks;
    fork
      cpu({3'h0, 10'h5, 10'h001}, 0, 1, 0);
      begin
        repeat (12) @(posedge CLK_I);
        #1 load = 1;
        @(posedge CLK_I); #1;
        load = 0;
      end
    join
    check(acks - a0, 6);
    check(ra, {9'h1A3, 10'h001});
    check(rd, {6'h23, 10'h001} ^ 16'h5A5A);
    $display("t_dma done");
  endtask : t_dma
  task automatic t_clk;
    int c16, c8;
    logic [5:0] p;
    {c16, c8, p} = {64'h0, clks};
    repeat (246) begin
      @(posedge CLK_I); #1;
      c16 += (clks[5] && !p[5]);
      c8 += (clks[4] && !p[4]);
      p = clks;
    end
    check(c16, 20);
    check(c8, 10);
    $display("t_clk done");
  endtask : t_clk
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #150000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge CLK_I);
    #1 RST_I = 0;
    t_clk();
    t_map();
    t_prot();
    t_io();
    t_dma();
    stop_test();
  end
endmodule : test_memory_state_machine_mapper
`default_nettype wire
